// ### pkg/dram_train_pkg.sv
// Shared constants and carriers for the SDRAM training logic
package dram_train_pkg;

  // Timing
  localparam int CLK_MHZ = 125;
  // Longest feedback delay after the sampling strobe edge, in ns
  localparam int WLO_NS  = 16;
  localparam int WLO_CYC = (WLO_NS * CLK_MHZ / 1000) < 1 ? 1 :
                           (WLO_NS * CLK_MHZ / 1000);

  // Register byte offsets
  localparam logic [4:0] ADR_CTRL   = 5'h00;
  localparam logic [4:0] ADR_STATUS = 5'h04;
  localparam logic [4:0] ADR_MR1    = 5'h08;
  localparam logic [4:0] ADR_MR3    = 5'h0C;

  // Control register fields
  localparam int CTRL_FB_ALL_BIT = 0;
  localparam int CTRL_COPY_BIT   = 1;
  localparam int CTRL_RL_LSB     = 8;
  localparam logic [3:0] RL_RESET = 4'h6;

  // Mode register fields and command address bits
  localparam int MR1_WL_BIT   = 7;
  localparam int MR1_QOFF_BIT = 12;
  localparam int MR3_PAT_BIT  = 2;
  localparam int RD_ORDER_BIT = 2;
  localparam int RD_BC_BIT    = 12;
  localparam logic [1:0] MR0_BL_OTF = 2'h1;
  localparam logic [1:0] MR0_BL_BC4 = 2'h2;
  localparam logic [1:0] LOC_PATTERN = 2'h0;
  localparam logic [2:0] BA_MR0 = 3'h0;
  localparam logic [2:0] BA_MR1 = 3'h1;
  localparam logic [2:0] BA_MR3 = 3'h3;

  // Burst figures and the predefined alternating pattern
  localparam logic [3:0] BEATS_BL8 = 4'h8;
  localparam logic [3:0] BEATS_BC4 = 4'h4;
  localparam logic [7:0] PATTERN   = 8'hAA;

  typedef enum logic [1:0] {
    RD_IDLE  = 2'h0,
    RD_WAIT  = 2'h1,
    RD_BURST = 2'h3
  } rd_state_t;

  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [14:0] a;
  } cmd_pins_t;

  typedef struct packed {
    logic        ck;
    logic        dqs;
    logic        odt;
    cmd_pins_t   cmd;
  } pins_in_t;

  typedef struct packed {
    logic [15:0] dq;
    logic [15:0] dq_oe;
    logic        rtt_dqs;
    logic        rtt_dq;
  } pad_out_t;

  typedef struct packed {
    pins_in_t    sync1;
    pins_in_t    sync2;
    logic        ck_d;
    logic        dqs_d;
    logic [1:0]  mr0_bl;
    logic [14:0] mr1;
    logic [2:0]  mr3;
    logic        fb_all;
    logic        copy_all;
    logic [3:0]  rl;
    logic [3:0]  pend_cnt;
    logic        pend_val;
    logic        fb;
    logic        sampled;
    rd_state_t   rd_state;
    logic [3:0]  rd_cnt;
    logic [2:0]  beat;
    logic [3:0]  left;
    logic        bc;
    pad_out_t    pad;
    logic        ack;
    logic [31:0] dat;
  } state_t;

endpackage

// ### src/dram_train_dev.sv
// Device-side write leveling and calibration pattern readout
`timescale 1ns/100ps
// What this block does
// - MR1 A7 set enters, cleared leaves leveling
// - Leveling: ODT switches strobe termination only
// - MR1 A12 one disables output drivers
// - Leveling exit MRS may change other bits
// - Rising strobe samples clock, feedback after delay
// - Feedback on bit 0 of each lane, others held low unless fb_all set
// - MR3 A2 set enables pattern register
// - Reads redirect to pattern register, A2 clears
// - Read with autoprecharge acts as plain read
// - Bit 0 of each lane carries pattern
// - Column A2 picks nibble order for chops
// - Chop bit honoured on the fly, rest ignored
// - Pattern reads use regular read latency
// - Burst bit 0 is pattern LSB
// - Location zero returns alternating zero-one pattern
// - A12 low chops burst to four beats
module dram_train_dev
  import dram_train_pkg::*;
#(
  parameter logic [3:0] RL_DEFAULT = RL_RESET
) (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [4:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output      logic [31:0] o_wb_dat,
  output      logic        o_wb_ack,
  input  wire logic        i_ck,
  input  wire logic        i_dqs,
  input  wire logic        i_odt,
  input  wire cmd_pins_t   i_cmd,
  output      pad_out_t    o_pad,
  output      logic        o_wl_active,
  output      logic        o_pattern_active
);

  localparam int FB_LAT = WLO_CYC + 2;

  state_t   st_ff;
  state_t   nxt_st;
  pins_in_t pins_now;
  logic     ck_rise;
  logic     dqs_rise;
  logic     cmd_sel;
  logic     is_mrs;
  logic     is_rd;
  logic     wb_go;
  logic     lvl_on;
  logic     qoff;
  logic     bit_now;

  // Refuse a feedback delay the pending counter cannot hold
  if (WLO_CYC > 15 || RL_DEFAULT == 4'h0) begin : g_bad_cfg
    $error("dram_train_dev: unsupported delay or latency");
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin sampling and command decode

  // All pins arrive from the controller, so all are synchronised
  assign pins_now = '{ck: i_ck, dqs: i_dqs, odt: i_odt, cmd: i_cmd};

  // Commands are taken at the clock edge found after synchronising;
  // the controller keeps them steady around that edge
  assign ck_rise  = st_ff.sync2.ck & ~st_ff.ck_d;
  assign dqs_rise = st_ff.sync2.dqs & ~st_ff.dqs_d;
  assign cmd_sel  = ck_rise & ~st_ff.sync2.cmd.cs_n;
  assign is_mrs   = cmd_sel & ~st_ff.sync2.cmd.ras_n &
                    ~st_ff.sync2.cmd.cas_n & ~st_ff.sync2.cmd.we_n;
  // Autoprecharge bit is not looked at, so RDA is a plain read
  assign is_rd    = cmd_sel & st_ff.sync2.cmd.ras_n &
                    ~st_ff.sync2.cmd.cas_n & st_ff.sync2.cmd.we_n;
  assign wb_go    = i_wb_cyc & i_wb_stb & ~st_ff.ack;
  assign lvl_on   = st_ff.mr1[MR1_WL_BIT];
  assign qoff     = st_ff.mr1[MR1_QOFF_BIT];

  // Current pattern bit; reserved locations read as zero
  assign bit_now  = (st_ff.mr3[1:0] == LOC_PATTERN) ?
                    PATTERN[st_ff.beat] : 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // One process for the whole block state
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.sync1 = pins_now;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.ck_d  = st_ff.sync2.ck;
    nxt_st.dqs_d = st_ff.sync2.dqs;

    // Mode register writes; the whole MR1 word is taken, so the
    // leveling exit may change any other field at once
    if (is_mrs) begin
      unique case (st_ff.sync2.cmd.ba)
        BA_MR0: nxt_st.mr0_bl = st_ff.sync2.cmd.a[1:0];
        BA_MR1: begin
          nxt_st.mr1 = st_ff.sync2.cmd.a;
          if (st_ff.sync2.cmd.a[MR1_WL_BIT] != lvl_on) begin
            nxt_st.sampled  = 1'b0;
            nxt_st.pend_cnt = 4'h0;
          end
        end
        BA_MR3: nxt_st.mr3 = st_ff.sync2.cmd.a[2:0];
        default: nxt_st.mr3 = st_ff.mr3;
      endcase
    end

    // Strobe edge captures clock level, released after the delay
    if (dqs_rise && lvl_on) begin
      nxt_st.pend_cnt = WLO_CYC[3:0];
      nxt_st.pend_val = st_ff.sync2.ck;
    end else if (st_ff.pend_cnt != 4'h0) begin
      nxt_st.pend_cnt = st_ff.pend_cnt - 4'h1;
      if (st_ff.pend_cnt == 4'h1) begin
        nxt_st.fb      = st_ff.pend_val;
        nxt_st.sampled = 1'b1;
      end
    end

    // Pattern read sequencer; a read arriving mid-burst is dropped
    unique case (st_ff.rd_state)
      RD_IDLE: begin
        if (is_rd && st_ff.mr3[MR3_PAT_BIT]) begin
          // Chop bit only counts when MR0 allows on-the-fly
          nxt_st.bc = (st_ff.mr0_bl == MR0_BL_OTF) ?
                      ~st_ff.sync2.cmd.a[RD_BC_BIT] :
                      (st_ff.mr0_bl == MR0_BL_BC4);
          // Bank bits, A10 and other column bits are not used
          nxt_st.beat = nxt_st.bc ?
                        {st_ff.sync2.cmd.a[RD_ORDER_BIT], 2'h0} :
                        3'h0;
          nxt_st.left = nxt_st.bc ? BEATS_BC4 : BEATS_BL8;
          nxt_st.rd_cnt   = st_ff.rl;
          nxt_st.rd_state = RD_WAIT;
        end
      end
      RD_WAIT: begin
        if (st_ff.rd_cnt <= 4'h1) begin
          nxt_st.rd_state = RD_BURST;
        end else begin
          nxt_st.rd_cnt = st_ff.rd_cnt - 4'h1;
        end
      end
      RD_BURST: begin
        nxt_st.beat = st_ff.beat + 3'h1;
        nxt_st.left = st_ff.left - 4'h1;
        if (st_ff.left == 4'h1) begin
          nxt_st.rd_state = RD_IDLE;
        end
      end
      default: nxt_st.rd_state = RD_IDLE;
    endcase

    // Pad drive: burst first, then leveling feedback
    nxt_st.pad.rtt_dqs = st_ff.sync2.odt;
    nxt_st.pad.rtt_dq  = st_ff.sync2.odt & ~lvl_on;
    nxt_st.pad.dq      = 16'h0000;
    nxt_st.pad.dq_oe   = 16'h0000;
    if (st_ff.rd_state == RD_BURST) begin
      nxt_st.pad.dq_oe = qoff ? 16'h0000 : 16'hFFFF;
      for (int i = 0; i < 16; i++) begin
        if (i % 8 == 0 || st_ff.copy_all) begin
          nxt_st.pad.dq[i] = bit_now;
        end
      end
    end else if (lvl_on && st_ff.sampled) begin
      // Before the first sample the pins stay undriven
      nxt_st.pad.dq_oe = qoff ? 16'h0000 : 16'hFFFF;
      for (int i = 0; i < 16; i++) begin
        if (i % 8 == 0 || st_ff.fb_all) begin
          nxt_st.pad.dq[i] = st_ff.fb;
        end
      end
    end

    // Register bus: single-cycle registered acknowledge
    nxt_st.ack = wb_go;
    if (wb_go) begin
      unique case (i_wb_adr)
        ADR_CTRL:   nxt_st.dat = {20'h0, st_ff.rl, 6'h0,
                                  st_ff.copy_all, st_ff.fb_all};
        ADR_STATUS: nxt_st.dat = {25'h0, st_ff.rd_state,
                                  st_ff.sampled, st_ff.fb, qoff,
                                  st_ff.mr3[MR3_PAT_BIT], lvl_on};
        ADR_MR1:    nxt_st.dat = {17'h0, st_ff.mr1};
        ADR_MR3:    nxt_st.dat = {27'h0, st_ff.mr0_bl, st_ff.mr3};
        default:    nxt_st.dat = 32'h0000_0000;
      endcase
      if (i_wb_we && i_wb_adr == ADR_CTRL) begin
        if (i_wb_sel[0]) begin
          nxt_st.fb_all   = i_wb_dat[CTRL_FB_ALL_BIT];
          nxt_st.copy_all = i_wb_dat[CTRL_COPY_BIT];
        end
        // Zero latency would collapse the wait state, so keep one
        if (i_wb_sel[1]) begin
          nxt_st.rl = (i_wb_dat[CTRL_RL_LSB +: 4] == 4'h0) ? 4'h1 :
                      i_wb_dat[CTRL_RL_LSB +: 4];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  // Asynchronous reset loads constants only
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_ff    <= '0;
      st_ff.rl <= RL_DEFAULT;
      // Idle chip select, so no phantom command after release
      st_ff.sync1.cmd.cs_n <= 1'b1;
      st_ff.sync2.cmd.cs_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state flops
  assign o_pad            = st_ff.pad;
  assign o_wb_ack         = st_ff.ack;
  assign o_wb_dat         = st_ff.dat;
  assign o_wl_active      = st_ff.mr1[MR1_WL_BIT];
  assign o_pattern_active = st_ff.mr3[MR3_PAT_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  a_wl_entry_exit: assert property (
    is_mrs && st_ff.sync2.cmd.ba == BA_MR1 |=>
      o_wl_active == $past(st_ff.sync2.cmd.a[MR1_WL_BIT]))
    else $error("leveling mode does not follow MR1 A7");

  a_wl_dq_term: assert property (
    o_wl_active |=> !o_pad.rtt_dq && o_pad.rtt_dqs == $past(st_ff.sync2.odt))
    else $error("data termination switched during leveling");

  a_qoff_quiet: assert property (
    st_ff.mr1[MR1_QOFF_BIT] ##1 st_ff.mr1[MR1_QOFF_BIT] |->
      o_pad.dq_oe == 16'h0000)
    else $error("drivers on with output buffer off");

  // Feedback stands FB_LAT clocks after the strobe edge was seen
  a_wl_feedback: assert property (
    dqs_rise && o_wl_active ##1 o_wl_active [*4] |->
      o_pad.dq[0] == $past(st_ff.sync2.ck, FB_LAT))
    else $error("feedback not the clock level after the delay");

  a_other_bits_low: assert property (
    lvl_on && st_ff.sampled && !st_ff.fb_all &&
      st_ff.rd_state == RD_IDLE |=>
      o_pad.dq[7:1] == 7'h00 && o_pad.dq[15:9] == 7'h00)
    else $error("non-prime data bits not held low");

  a_pattern_enable: assert property (
    is_mrs && st_ff.sync2.cmd.ba == BA_MR3 |=>
      o_pattern_active == $past(st_ff.sync2.cmd.a[MR3_PAT_BIT]))
    else $error("pattern mode does not follow MR3 A2");

  a_burst_eight: assert property (
    $rose(st_ff.rd_state == RD_BURST) && !st_ff.bc |->
      (st_ff.rd_state == RD_BURST) [*8] ##1 st_ff.rd_state == RD_IDLE)
    else $error("full burst not eight beats");

  a_burst_four: assert property (
    $rose(st_ff.rd_state == RD_BURST) && st_ff.bc |->
      (st_ff.rd_state == RD_BURST) [*4] ##1 st_ff.rd_state == RD_IDLE)
    else $error("chopped burst not four beats");

  a_pattern_map: assert property (
    st_ff.rd_state == RD_BURST && st_ff.mr3[1:0] == LOC_PATTERN |=>
      o_pad.dq[0] == PATTERN[$past(st_ff.beat)] &&
      o_pad.dq[8] == o_pad.dq[0])
    else $error("pattern bit does not match burst position");

  a_rd_latency: assert property (
    st_ff.rd_state == RD_IDLE && is_rd && o_pattern_active |=>
      st_ff.rd_state == RD_WAIT ##[1:15] st_ff.rd_state == RD_BURST)
    else $error("pattern read did not start within latency");

  a_read_ignored: assert property (
    is_rd && !o_pattern_active && st_ff.rd_state == RD_IDLE |=>
      st_ff.rd_state == RD_IDLE)
    else $error("read acted on outside pattern mode");

  a_bl8_order: assert property (
    $rose(st_ff.rd_state == RD_BURST) && !st_ff.bc |->
      st_ff.beat == 3'h0)
    else $error("full burst does not start at beat zero");

  a_bc4_nibble: assert property (
    $rose(st_ff.rd_state == RD_BURST) && st_ff.bc |->
      st_ff.beat[1:0] == 2'h0)
    else $error("chopped burst not on a nibble boundary");

  a_reserved_zero: assert property (
    st_ff.rd_state == RD_BURST && st_ff.mr3[1:0] != LOC_PATTERN |=>
      o_pad.dq == 16'h0000)
    else $error("reserved location returned data");

  a_copy_lanes: assert property (
    st_ff.rd_state == RD_BURST && st_ff.copy_all |=>
      o_pad.dq == {16{o_pad.dq[0]}})
    else $error("pattern bit not copied to every data bit");

  a_burst_drive: assert property (
    st_ff.rd_state == RD_BURST && !qoff |=> o_pad.dq_oe == 16'hFFFF)
    else $error("drivers off during a burst with buffer on");

  // Outside leveling both terminations follow the ODT pin
  a_normal_term: assert property (
    !o_wl_active |=> o_pad.rtt_dq == $past(st_ff.sync2.odt) &&
      o_pad.rtt_dqs == o_pad.rtt_dq)
    else $error("termination outside leveling not set by ODT");

  c_wl_high: cover property (
    lvl_on && st_ff.pend_cnt == 4'h1 && st_ff.pend_val);
  c_bl8_read: cover property (
    $rose(st_ff.rd_state == RD_BURST) && !st_ff.bc);
  c_bc4_upper: cover property (
    $rose(st_ff.rd_state == RD_BURST) && st_ff.bc && st_ff.beat[2]);
  c_bus_write: cover property (wb_go && i_wb_we);
  c_wl_exit: cover property ($fell(o_wl_active));

endmodule

// ### test/ctl_model.sv
// Memory controller model driving the device's pin side
`timescale 1ns/100ps
module ctl_model
  import dram_train_pkg::*;
#(
  parameter int T_MOD_CK = 4
) (
  output logic      o_ck,
  output logic      o_dqs,
  output logic      o_odt,
  output cmd_pins_t o_cmd
);
  // Free-running CK, phase unrelated to the system clock
  initial begin
    o_ck = 1'b0;
    o_dqs = 1'b0;
    o_odt = 1'b0;
    o_cmd = {4'hF, 18'h00000};
    #3.3;
    forever #40 o_ck = ~o_ck;
  end

  // Launch on CK fall so the pins are steady at the rise
  task automatic issue(input logic [2:0] c, input logic [2:0] ba,
                       input logic [14:0] a);
    @(negedge o_ck);
    o_cmd <= {1'b0, c, ba, a};
    @(negedge o_ck);
    o_cmd <= {1'b1, ~c, ~ba, ~a}; // Deselected bus shows no stale value
    repeat (T_MOD_CK) @(negedge o_ck);
  endtask

  // Single rising strobe edge at a set delay after CK fall
  task automatic strobe(input int d);
    @(negedge o_ck);
    #d o_dqs = 1'b1;
    #20 o_dqs = 1'b0;
    repeat (2) @(negedge o_ck);
  endtask

  task automatic set_odt(input logic v);
    @(negedge o_ck);
    o_odt <= v;
    repeat (2) @(negedge o_ck);
  endtask

  // Strobe parked high: driven to one, not left at its last level
  task automatic rel();
    o_dqs = 1'b1;
  endtask
endmodule

// ### test/dram_train_dev_tb.sv
// Self-checking bench for the SDRAM training block
`timescale 1ns/100ps
module dram_train_dev_tb;
  import dram_train_pkg::*;
  logic        i_clk, i_resetn, cyc, stb, we, ack, wl, pat, ck, dqs, odt;
  logic [4:0]  adr;
  logic [31:0] wdat, rdat, q, r;
  cmd_pins_t   cmd;
  pad_out_t    pad;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          rl, lock, prev, e;
  logic [31:0] seed = 32'h00017C33;
  localparam logic [14:0] RTT = 15'h0004; // Nominal termination, plain default

  always #4 i_clk = ~i_clk;

  dram_train_dev dram_train_dev_inst (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_ck(ck), .i_dqs(dqs), .i_odt(odt), .i_cmd(cmd), .o_pad(pad),
    .o_wl_active(wl), .o_pattern_active(pat));
  ctl_model ctl_model_inst (.o_ck(ck), .o_dqs(dqs), .o_odt(odt),
    .o_cmd(cmd));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Model of the data pins: bit 0 of each lane, or copied to all
  function automatic logic [15:0] lanes(input int b, input int all);
    return all ? {16{b[0]}} : {7'h00, b[0], 7'h00, b[0]};
  endfunction

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] %0t reg got %h exp %h", $time, g, x);
    end
  endtask

  task automatic chk_pin(input logic [15:0] g, input logic [15:0] x);
    check_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] %0t pin got %h exp %h", $time, g, x);
    end
  endtask

  // Classic single cycle; holds until ack is sampled
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    if (n >= 16) n_mismatch++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] x);
    wb(1'b0, a, 32'h00000000);
    chk_reg(q, x);
  endtask

  // Waits for the burst, then checks every beat and the release
  task automatic burst(input int n, input int st, input int loc0,
                       input int cp);
    int k;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (pad.dq_oe[0] !== 1'b1 && k < 64);
    for (k = 0; k < n; k++) begin
      chk_pin(pad.dq, lanes(loc0 ? (st + k) % 2 : 0, cp));
      @(posedge i_clk);
    end
    chk_pin(pad.dq_oe, 16'h0000);
  endtask

  // Read with random don't-care bank, column and autoprecharge bits
  task automatic pread(input logic [14:0] a, input int n, input int st,
                       input int loc0, input int cp);
    logic [31:0] x;
    x = rnd();
    fork
      ctl_model_inst.issue(3'b101, x[18:16], a | (x[14:0] & 15'h6FF8));
      burst(n, st, loc0, cp);
    join
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog, well past the expected run of some 10 us
  initial begin
    #400000;
    n_mismatch++;
    final_report();
  end

  initial begin
    i_clk = 1'b0;
    i_resetn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 5'h00;
    wdat = 32'h00000000;
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'b1;
    rd_chk(ADR_CTRL, {20'h00000, RL_RESET, 8'h00});
    rd_chk(5'h10, 32'h00000000);
    wb(1'b1, ADR_STATUS, 32'hFFFFFFFF);
    rd_chk(ADR_STATUS, 32'h00000000);
    r = rnd() & 32'h00000F00;
    rl = (r[11:8] == 4'h0) ? 1 : r[11:8];
    wb(1'b1, ADR_CTRL, r);
    rd_chk(ADR_CTRL, rl << 8);
    $display("test registers done");
    // Leveling: only MRS and NOP from here until exit
    ctl_model_inst.issue(3'b000, BA_MR1, 15'h0080 | RTT);
    chk_reg({31'h0, wl}, 32'h00000001);
    chk_pin({14'h0, pad.rtt_dqs, pad.rtt_dq}, 16'h0000);
    ctl_model_inst.set_odt(1'b1);
    chk_pin({14'h0, pad.rtt_dqs, pad.rtt_dq}, 16'h0002);
    // Sweep the strobe delay and lock on the first 0 to 1
    lock = -1;
    prev = 0;
    for (int d = 10; d < 80; d += 20) begin
      ctl_model_inst.strobe(d);
      e = (d >= 40);
      chk_pin(pad.dq, lanes(e, 0));
      chk_pin(pad.dq_oe, 16'hFFFF);
      if (lock < 0 && prev == 0 && pad.dq[0] === 1'b1) lock = d;
      prev = (pad.dq[0] === 1'b1);
    end
    chk_reg(lock, 50);
    wb(1'b1, ADR_CTRL, (rl << 8) | 32'h1);
    ctl_model_inst.strobe(50);
    chk_pin(pad.dq, 16'hFFFF);
    wb(1'b1, ADR_CTRL, rl << 8);
    rd_chk(ADR_STATUS, 32'h00000019);
    ctl_model_inst.issue(3'b000, BA_MR1, 15'h1080 | RTT);
    ctl_model_inst.strobe(50);
    chk_pin(pad.dq_oe, 16'h0000);
    rd_chk(ADR_STATUS, 32'h0000001D);
    ctl_model_inst.rel();
    ctl_model_inst.set_odt(1'b0);
    chk_pin({14'h0, pad.rtt_dqs, pad.rtt_dq}, 16'h0000);
    ctl_model_inst.issue(3'b000, BA_MR1, 15'h0266);
    chk_reg({31'h0, wl}, 32'h00000000);
    rd_chk(ADR_MR1, 32'h00000266);
    $display("test leveling done");
    // Pattern readout
    ctl_model_inst.issue(3'b000, BA_MR0, {13'h0000, MR0_BL_OTF});
    ctl_model_inst.issue(3'b000, BA_MR3, 15'h0004);
    chk_reg({31'h0, pat}, 32'h00000001);
    rd_chk(ADR_MR3, {27'h0, MR0_BL_OTF, 3'h4});
    for (int i = 0; i < 3; i++)
      pread({2'h0, i == 0, 9'h000, i == 2, 2'h0}, i == 0 ? 8 : 4,
            i == 2 ? 4 : 0, 1, 0);
    wb(1'b1, ADR_CTRL, (rl << 8) | 32'h2);
    pread(15'h1000, 8, 0, 1, 1);
    ctl_model_inst.issue(3'b000, BA_MR3, 15'h0005);
    pread(15'h1000, 8, 0, 0, 1);
    ctl_model_inst.issue(3'b000, BA_MR3, 15'h0000);
    chk_reg({31'h0, pat}, 32'h00000000);
    // Watch the pins across the read: a burst would fall inside it
    r = 32'h00000000;
    fork
      ctl_model_inst.issue(3'b101, 3'h0, 15'h1000);
      repeat (60) begin
        @(posedge i_clk);
        r[15:0] = r[15:0] | pad.dq_oe;
      end
    join
    chk_pin(r[15:0], 16'h0000);
    $display("test pattern done");
    final_report();
  end
endmodule
